// File: rtl/pgst_timekeeper.sv
// Serial timekeeper hidden behind a memory chip-select path.
`timescale 1ns/10ps
module pgst_timekeeper
   import pgst_pkg::*;
#(
   parameter int OSC_HZ  = PGST_OSC_HZ,
   parameter int TICK_HZ = PGST_TICK_HZ
) (
   input  wire logic sys_clk,
   input  wire logic srst,
   input  wire logic chip_select_in_n,
   input  wire logic output_enable_n,
   input  wire logic write_enable_n,
   input  wire logic data_in,
   input  wire logic reset_pin_n,
   input  wire logic rom_select,
   input  wire logic power_fail,
   input  wire logic osc_in,
   output logic      chip_select_out_n_q,
   output logic      data_out_q,
   output logic      data_out_oe_q
);
   localparam int AW = $clog2(OSC_HZ) + 1;
   localparam logic [AW-1:0] OSC_W  = AW'(OSC_HZ);
   localparam logic [AW-1:0] TICK_W = AW'(TICK_HZ);

   // =========================================================
   // BCD helpers
   // =========================================================
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
   endfunction : bcd_inc

   function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
      logic leap;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      unique case (mon)
         8'h02:                      month_days = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
         default:                    month_days = 8'h31;
      endcase
   endfunction : month_days

   // =========================================================
   // Bus cycle tracking
   // =========================================================
   logic           ce_prev_q, ce_prev_d;
   logic           rd_seen_q, rd_seen_d, wr_seen_q, wr_seen_d;
   logic           din_q, din_d;
   logic           osc_prev_q;
   logic [AW-1:0]  acc_q, acc_d;
   pgst_state_type state_q, state_d;
   logic [5:0]     ptr_q, ptr_d;
   logic [7:0]     shad_q [PGST_NREG];
   logic [7:0]     shad_d [PGST_NREG];
   logic [7:0]     time_q [PGST_NREG];
   logic [7:0]     time_d [PGST_NREG];
   logic           cyc_end, is_wr, is_rd, abort, tick, commit;
   logic           ceo_d, dout_d, doe_d;
   logic [AW:0]    acc_sum;
   logic [7:0]     hr, h12n;

   always_comb begin
      ce_prev_d = chip_select_in_n;
      rd_seen_d = rd_seen_q;
      wr_seen_d = wr_seen_q;
      din_d     = din_q;
      if (!chip_select_in_n) begin
         if (!output_enable_n) rd_seen_d = 1'b1;
         if (!write_enable_n) begin
            wr_seen_d = 1'b1;
            din_d     = data_in;
         end
      end else begin
         rd_seen_d = 1'b0;
         wr_seen_d = 1'b0;
      end
      // A cycle is acted on when chip select rises, so unselected cycles are ignored.
      cyc_end = chip_select_in_n && !ce_prev_q;
      is_wr   = cyc_end && wr_seen_q;
      is_rd   = cyc_end && rd_seen_q && !wr_seen_q;
      abort   = power_fail || (!reset_pin_n && !time_q[PGST_R_DAY][PGST_DAY_RMK]);
   end

   // =========================================================
   // Unlock and transfer sequencer
   // =========================================================
   always_comb begin
      state_d = state_q;
      ptr_d   = ptr_q;
      shad_d  = shad_q;
      commit  = 1'b0;
      if (abort) begin
         state_d = PGST_DEAD;
         ptr_d   = 6'h00;
      end else begin
         unique case (state_q)
            PGST_DEAD: begin
               if (is_rd) begin
                  state_d = PGST_MATCH;
                  ptr_d   = 6'h00;
               end
            end
            PGST_MATCH: begin
               if (is_rd) begin
                  ptr_d = 6'h00;
               end else if (is_wr) begin
                  if (din_q == PGST_PATTERN[ptr_q]) begin
                     ptr_d = ptr_q + 6'h01;
                     if (ptr_q == 6'h3f) begin
                        state_d = PGST_XFER;
                        shad_d  = time_q;
                     end
                  end else begin
                     state_d = PGST_DEAD;
                  end
               end
            end
            PGST_XFER: begin
               if (is_rd || is_wr) begin
                  ptr_d = ptr_q + 6'h01;
                  if (is_wr) begin
                     shad_d[ptr_q[5:3]][ptr_q[2:0]] = din_q;
                     commit = (ptr_q[2:0] == 3'h7);
                  end
                  if (ptr_q == 6'h3f) state_d = PGST_DEAD;
               end
            end
         endcase
      end
   end

   // =========================================================
   // Timebase and calendar
   // =========================================================
   always_comb begin
      acc_sum = {1'b0, acc_q} + {1'b0, TICK_W};
      tick    = 1'b0;
      acc_d   = acc_q;
      time_d  = time_q;
      h12n    = 8'h00;
      hr      = time_q[PGST_R_HOUR];
      // Ticks 100 per osc period of OSC_HZ cycles, so seconds stay exact.
      if (osc_in && !osc_prev_q && !time_q[PGST_R_DAY][PGST_DAY_OSC]) begin
         if (acc_sum[AW-1:0] >= OSC_W) begin
            acc_d = acc_sum[AW-1:0] - OSC_W;
            tick  = 1'b1;
         end else begin
            acc_d = acc_sum[AW-1:0];
         end
      end
      if (tick) begin
         time_d[PGST_R_HUND] = bcd_inc(time_q[PGST_R_HUND]);
         if (time_q[PGST_R_HUND] == 8'h99) begin
            time_d[PGST_R_HUND] = 8'h00;
            time_d[PGST_R_SEC]  = bcd_inc(time_q[PGST_R_SEC]);
            if (time_q[PGST_R_SEC] == 8'h59) begin
               time_d[PGST_R_SEC] = 8'h00;
               time_d[PGST_R_MIN] = bcd_inc(time_q[PGST_R_MIN]);
               if (time_q[PGST_R_MIN] == 8'h59) begin
                  time_d[PGST_R_MIN] = 8'h00;
                  if (hr[PGST_HR_12]) begin
                     h12n = (hr[4:0] == 5'h12) ? 8'h01 : bcd_inc({3'h0, hr[4:0]});
                     time_d[PGST_R_HOUR] = {hr[7:6], hr[PGST_HR_PM] ^ (hr[4:0] == 5'h11), h12n[4:0]};
                  end else begin
                     h12n = bcd_inc({2'h0, hr[5:0]});
                     time_d[PGST_R_HOUR] = (hr[5:0] == 6'h23) ? {hr[7:6], 6'h00} : {hr[7:6], h12n[5:0]};
                  end
                  if (hr[PGST_HR_12] ? (hr[PGST_HR_PM] && hr[4:0] == 5'h11) : (hr[5:0] == 6'h23)) begin
                     time_d[PGST_R_DAY][2:0] = (time_q[PGST_R_DAY][2:0] == 3'h7) ? 3'h1
                                                : time_q[PGST_R_DAY][2:0] + 3'h1;
                     time_d[PGST_R_DATE] = bcd_inc(time_q[PGST_R_DATE]);
                     if (time_q[PGST_R_DATE] == month_days(time_q[PGST_R_MON], time_q[PGST_R_YEAR])) begin
                        time_d[PGST_R_DATE] = 8'h01;
                        time_d[PGST_R_MON]  = bcd_inc(time_q[PGST_R_MON]);
                        if (time_q[PGST_R_MON] == 8'h12) begin
                           time_d[PGST_R_MON]  = 8'h01;
                           time_d[PGST_R_YEAR] = (time_q[PGST_R_YEAR] == 8'h99) ? 8'h00
                                                 : bcd_inc(time_q[PGST_R_YEAR]);
                        end
                     end
                  end
               end
            end
         end
      end
      // A completed byte replaces the live register; unused bits stay zero.
      if (commit) begin
         time_d[ptr_q[5:3]] = shad_d[ptr_q[5:3]] & PGST_MASKS[8*ptr_q[5:3] +: 8];
      end
   end

   // =========================================================
   // Pin outputs
   // =========================================================
   always_comb begin
      if (power_fail) begin
         ceo_d = !rom_select;
      end else if (state_q == PGST_XFER) begin
         ceo_d = 1'b1;
      end else begin
         ceo_d = chip_select_in_n;
      end
      doe_d  = (state_q == PGST_XFER) && !abort && !chip_select_in_n && !output_enable_n && write_enable_n;
      dout_d = shad_q[ptr_q[5:3]][ptr_q[2:0]];
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ce_prev_q           <= 1'b1;
         rd_seen_q           <= 1'b0;
         wr_seen_q           <= 1'b0;
         din_q               <= 1'b0;
         osc_prev_q          <= 1'b0;
         acc_q               <= '0;
         state_q             <= PGST_DEAD;
         ptr_q               <= 6'h00;
         chip_select_out_n_q <= 1'b1;
         data_out_q          <= 1'b0;
         data_out_oe_q       <= 1'b0;
         for (int i = 0; i < PGST_NREG; i++) begin
            shad_q[i] <= 8'h00;
            time_q[i] <= PGST_RESET[8*i +: 8];
         end
      end else begin
         ce_prev_q           <= ce_prev_d;
         rd_seen_q           <= rd_seen_d;
         wr_seen_q           <= wr_seen_d;
         din_q               <= din_d;
         osc_prev_q          <= osc_in;
         acc_q               <= acc_d;
         state_q             <= state_d;
         ptr_q               <= ptr_d;
         chip_select_out_n_q <= ceo_d;
         data_out_q          <= dout_d;
         data_out_oe_q       <= doe_d;
         shad_q              <= shad_d;
         time_q              <= time_d;
      end
   end

   // =========================================================
   // Checks
   // =========================================================
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   xfer_ceo_high_a: assert property (state_q == PGST_XFER && !power_fail |=> chip_select_out_n_q)
      else $error("memory select low during transfer");
   ram_pf_ceo_a: assert property (power_fail && !rom_select |=> chip_select_out_n_q)
      else $error("RAM mode power fail left memory select low");
   rom_pf_ceo_a: assert property (power_fail && rom_select |=> !chip_select_out_n_q)
      else $error("ROM mode power fail left memory select high");
   ceo_follow_a: assert property (!power_fail && state_q != PGST_XFER
                                  |=> chip_select_out_n_q == $past(chip_select_in_n))
      else $error("memory select did not follow chip select");
   pf_abort_a: assert property (power_fail |=> state_q == PGST_DEAD && !data_out_oe_q)
      else $error("power fail did not abort access");
   read_restart_a: assert property (state_q == PGST_MATCH && is_rd && !abort
                                    |=> state_q == PGST_MATCH && ptr_q == 6'h00)
      else $error("read did not restart matching");
   mismatch_dead_a: assert property (state_q == PGST_MATCH && is_wr && !abort && din_q != PGST_PATTERN[ptr_q]
                                     |=> state_q == PGST_DEAD ##1 state_q == PGST_DEAD || $past(is_rd))
      else $error("mismatched write not locked out");
   idle_hold_a: assert property (!cyc_end && !abort |=> $stable(ptr_q) && $stable(state_q))
      else $error("pointer moved without a bus cycle");
   pin_abort_a: assert property (!reset_pin_n && !time_q[PGST_R_DAY][PGST_DAY_RMK] |=> state_q == PGST_DEAD)
      else $error("unmasked abort pin ignored");
   zero_bits_a: assert property ((time_q[PGST_R_SEC][7] | time_q[PGST_R_HOUR][6] | time_q[PGST_R_MON][7])
                                 == 1'b0)
      else $error("unused register bit set");
endmodule : pgst_timekeeper

// File: rtl/pgst_pkg.sv
// Constants and types shared by the pattern-gated serial timekeeper.
package pgst_pkg;
   localparam logic [63:0] PGST_PATTERN = 64'h5ca3_3ac5_5ca3_3ac5;
   localparam int          PGST_OSC_HZ  = 32768;
   localparam int          PGST_TICK_HZ = 100;
   localparam int          PGST_NREG    = 8;
   localparam logic [2:0]  PGST_R_HUND  = 3'h0;
   localparam logic [2:0]  PGST_R_SEC   = 3'h1;
   localparam logic [2:0]  PGST_R_MIN   = 3'h2;
   localparam logic [2:0]  PGST_R_HOUR  = 3'h3;
   localparam logic [2:0]  PGST_R_DAY   = 3'h4;
   localparam logic [2:0]  PGST_R_DATE  = 3'h5;
   localparam logic [2:0]  PGST_R_MON   = 3'h6;
   localparam logic [2:0]  PGST_R_YEAR  = 3'h7;
   localparam int          PGST_HR_12   = 7;
   localparam int          PGST_HR_PM   = 5;
   localparam int          PGST_DAY_RMK = 4;
   localparam int          PGST_DAY_OSC = 5;
   localparam logic [63:0] PGST_MASKS   = 64'hff1f_3f37_bf7f_7fff;
   localparam logic [63:0] PGST_RESET   = 64'h0001_0101_0000_0000;
   typedef enum logic [1:0] {PGST_DEAD, PGST_MATCH, PGST_XFER} pgst_state_type;
endpackage : pgst_pkg

// File: sim/pgst_host_model.sv
// Host bus model that issues one memory cycle at a time to the timekeeper.
`timescale 1ns/10ps
module pgst_host_model (
   input  wire logic sys_clk,
   output logic      ce_n,
   output logic      oe_n,
   output logic      we_n,
   output logic      d,
   input  wire logic q,
   input  wire logic q_oe,
   input  wire logic cso_n
);
   initial begin
      ce_n = 1'b1;
      oe_n = 1'b1;
      we_n = 1'b1;
      d    = 1'b0;
   end

   // ==========================================================
   // One selected cycle, then a foreign write with chip select high.
   task automatic cyc(input logic wr, input logic b, output logic rq, output logic roe, output logic rcs);
      @(posedge sys_clk);
      ce_n <= 1'b0;
      we_n <= ~wr;
      oe_n <= wr;
      d    <= b;
      repeat (2) @(posedge sys_clk);
      #1;
      // An undriven data line reads as the inverse, so a missing enable shows up as bad data.
      rq  = q_oe ? q : ~q;
      roe = q_oe;
      rcs = cso_n;
      @(posedge sys_clk);
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      d    <= ~b;
      @(posedge sys_clk);
      we_n <= 1'b0;
      @(posedge sys_clk);
      we_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
   endtask : cyc

   // Chip select alone, for the pass-through cases.
   task automatic drive_ce(input logic v);
      ce_n <= v;
   endtask : drive_ce
endmodule : pgst_host_model

// File: sim/tb_top.sv
// Self-checking bench for the pattern-gated serial timekeeper.
`timescale 1ns/10ps
module tb_top
   import pgst_pkg::*;
;
   logic        sys_clk, srst, reset_pin_n, rom_select, power_fail, osc_in;
   logic        ce_n, oe_n, we_n, d, cso_n, q, q_oe;
   logic        rq, roe, rcs, cs_or, cs_and, oe_and;
   logic [63:0] v;
   int          num_errors, cmp_count;
   localparam logic [63:0] WVAL = 64'h9912_3117_b1d9_4599;
   localparam logic [63:0] WEXP = 64'h9912_3117_b159_4599;
   logic [3:0]  rows [8] = '{4'b0000, 4'b1001, 4'b0010, 4'b1011, 4'b0101, 4'b1101, 4'b0110, 4'b1110};
   logic [63:0] cal_set [5] = '{64'h2104_3007_2359_5999, 64'h2402_2803_b159_5999, 64'h2302_2805_2359_5999,
                               64'h2104_3027_2359_5999, 64'h2104_3001_0000_0000};
   logic [63:0] cal_exp [5] = '{64'h2105_0101_0000_0000, 64'h2402_2904_9200_0000, 64'h2303_0106_0000_0000,
                               64'h2104_3027_2359_5999, 64'h2104_3001_0000_0100};
   int          cal_edges [5] = '{2, 2, 2, 2, 200};

   // A short oscillator period keeps the calendar cases within a few thousand cycles.
   pgst_timekeeper #(.OSC_HZ(200)) dut (.sys_clk(sys_clk), .srst(srst), .chip_select_in_n(ce_n),
      .output_enable_n(oe_n),
      .write_enable_n(we_n), .data_in(d), .reset_pin_n(reset_pin_n), .rom_select(rom_select),
      .power_fail(power_fail), .osc_in(osc_in), .chip_select_out_n_q(cso_n), .data_out_q(q),
      .data_out_oe_q(q_oe));
   pgst_host_model host (.sys_clk(sys_clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .d(d), .q(q),
      .q_oe(q_oe), .cso_n(cso_n));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // ==========================================================
   // Checking and bus helpers.
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic op(input logic wr, input logic b);
      host.cyc(wr, b, rq, roe, rcs);
      cs_or  |= rcs;
      cs_and &= rcs;
      oe_and &= roe;
   endtask : op

   task automatic unlock();
      op(1'b0, 1'b0);
      cs_or = 1'b0;
      for (int i = 0; i < 64; i++) op(1'b1, PGST_PATTERN[i]);
      check(cs_or, 1'b0);
   endtask : unlock

   task automatic rd64(output logic [63:0] r);
      cs_and = 1'b1;
      oe_and = 1'b1;
      for (int i = 0; i < 64; i++) begin
         op(1'b0, 1'b0);
         r[i] = rq;
      end
      check(cs_and, 1'b1);
      check(oe_and, 1'b1);
   endtask : rd64

   task automatic part_pulse(input logic pin);
      unlock();
      // Twelve bits complete byte 0 and leave byte 1 half written when the abort lands.
      for (int i = 0; i < 12; i++) op(1'b1, ~WVAL[i]);
      @(posedge sys_clk);
      if (pin) power_fail <= 1'b1;
      else reset_pin_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      power_fail  <= 1'b0;
      reset_pin_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
   endtask : part_pulse

   task automatic osc_edges(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         osc_in <= 1'b1;
         @(posedge sys_clk);
         osc_in <= 1'b0;
      end
   endtask : osc_edges

   task automatic wr64(input logic [63:0] val);
      unlock();
      for (int i = 0; i < 64; i++) op(1'b1, val[i]);
   endtask : wr64

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : wrap_up

   // ==========================================================
   // Main sequence.
   initial begin
      num_errors = 0;
      cmp_count  = 0;
      srst = 1'b1;
      reset_pin_n = 1'b1;
      rom_select = 1'b0;
      power_fail = 1'b0;
      osc_in = 1'b0;
      repeat (20) @(posedge sys_clk);
      srst <= 1'b0;
      #1;
      check(cso_n, 1'b1); // RESET
      check(q_oe, 1'b0); // RESET
      foreach (rows[i]) begin
         @(posedge sys_clk);
         host.drive_ce(rows[i][3]);
         power_fail <= rows[i][2];
         rom_select <= rows[i][1];
         repeat (3) @(posedge sys_clk);
         #1;
         check(cso_n, rows[i][0]);
      end
      @(posedge sys_clk);
      host.drive_ce(1'b1);
      power_fail <= 1'b0;
      rom_select <= 1'b0;
      repeat (3) @(posedge sys_clk);
      unlock();
      rd64(v);
      check(v, PGST_RESET);
      op(1'b0, 1'b0);
      check(rcs, 1'b0);
      op(1'b0, 1'b0);
      for (int i = 0; i < 64; i++) op(1'b1, PGST_PATTERN[i] ^ (i == 3));
      op(1'b0, 1'b0);
      check({rcs, roe}, 2'b00);
      for (int i = 0; i < 10; i++) op(1'b1, PGST_PATTERN[i]);
      part_pulse(1'b0);
      unlock();
      rd64(v);
      check(v, {PGST_RESET[63:8], ~WVAL[7:0]});
      unlock();
      for (int i = 0; i < 64; i++) op(1'b1, WVAL[i]);
      unlock();
      rd64(v);
      check(v, WEXP);
      part_pulse(1'b1);
      unlock();
      rd64(v);
      check(v, {WEXP[63:8], ~WVAL[7:0]});
      unlock();
      reset_pin_n <= 1'b0;
      rd64(v);
      check(v, {WEXP[63:8], ~WVAL[7:0]});
      reset_pin_n <= 1'b1;
      srst        <= 1'b1;
      repeat (20) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      check({cso_n, q_oe}, 2'b10); // RESET
      unlock();
      rd64(v);
      check(v, PGST_RESET); // RESET
      foreach (cal_set[i]) begin
         wr64(cal_set[i]);
         osc_edges(cal_edges[i]);
         unlock();
         rd64(v);
         check(v, cal_exp[i]);
      end
      wrap_up();
   end

   initial begin
      #1_000_000;
      num_errors++;
      wrap_up();
   end
endmodule : tb_top
